// ===== core/adccfg_pkg.sv
/*
 * Shared constants and types for the converter configuration register slice:
 * register indices, field positions, reset values, timing and carriers.
 * Assumes a single 50 MHz APB clock domain.
 */
package adccfg_pkg;

   // Clock period of pclk
   localparam int CLK_PERIOD_NS = 20;

   // Register indices; the byte address is four times the index
   localparam logic [5:0] IDX_MODE = 6'h02;
   localparam logic [5:0] IDX_CLOCK = 6'h03;
   localparam logic [5:0] IDX_GAIN = 6'h04;
   localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
   localparam logic [7:0] ADDR_MODE = {IDX_MODE, 2'b00};
   localparam logic [7:0] ADDR_CLOCK = {IDX_CLOCK, 2'b00};
   localparam logic [7:0] ADDR_GAIN = {IDX_GAIN, 2'b00};
   localparam logic [7:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
   localparam logic [7:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

   // Reset values and writable masks
   localparam logic [15:0] MODE_RST = 16'h0510;
   localparam logic [15:0] CLOCK_RST = 16'h030e;
   localparam logic [15:0] CLOCK_WMASK = 16'h03ff;
   localparam logic [15:0] GAIN_RST = 16'h0000;
   localparam logic [2:0] IRQ_RST = 3'h0;

   // Mode register field positions
   localparam int MODE_FMT_BIT = 0;
   localparam int MODE_FLOAT_BIT = 1;
   localparam int MODE_SEL_LSB = 2;
   // Clock register field positions
   localparam int CLK_PWR_LSB = 0;
   localparam int CLK_OSR_LSB = 2;
   localparam int CLK_FAST_BIT = 5;
   localparam int CLK_CH0_BIT = 8;
   localparam int CLK_CH1_BIT = 9;
   // Gain register field positions
   localparam int GAIN_CH0_LSB = 0;
   localparam int GAIN_CH1_LSB = 4;
   // Interrupt status bit positions
   localparam int IRQ_READY_BIT = 0;
   localparam int IRQ_CH0_BIT = 1;
   localparam int IRQ_CH1_BIT = 2;

   // Ready source selector codes
   localparam logic [1:0] SEL_LAGGING = 2'h0;
   localparam logic [1:0] SEL_ANY = 2'h1;

   // Ratio used by the fixed override
   localparam logic [14:0] OSR_FAST = 15'h0040;

   // Low pulse width on the ready pin
   localparam int PULSE_NS = 80;
   localparam int PULSE_CYC_I = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] PULSE_CYC = 3'(PULSE_CYC_I);

   // Power level decode
   typedef enum logic [1:0] {PWR_VLOW, PWR_LOW, PWR_HRES} adccfg_pwr_t;

   // Ready pin driver states
   typedef enum logic [1:0] {PIN_IDLE, PIN_HOLD, PIN_PULSE} adccfg_pin_t;

   // Decoded configuration handed to the converter core
   typedef struct packed {
      logic [1:0] chan_on;
      logic [14:0] osr;
      adccfg_pwr_t power;
      logic [7:0] gain0;
      logic [7:0] amp_gain_config;
   } adccfg_cfg_t;

endpackage

// ===== core/adccfg_regs.sv
/*
 * APB register slice of a two-channel converter: interface mode, clock and
 * amplifier gain registers, conversion-ready pin driver and interrupts.
 * Assumes channel result pulses and the data-taken pulse come from logic
 * on pclk; the pin wire level is resolved outside from the enable.
 */
// Operation
// RULE1 - Two-bit selector picks ready pin source
// RULE2 - Idle pin drives high or floats
// RULE3 - Ready shown as held low or pulse
// RULE4 - Bits 9 and 8 enable channels
// RULE5 - Override bit 5 forces ratio 64
// RULE6 - Ratio field decodes 128 through 16256
// RULE7 - Power field decodes three power levels
// RULE8 - Clock register index 3, upper bits zero
// RULE9 - Gain register index 4, resets zero
// RULE10 - Gain codes in bits 6:4, 2:0
// RULE11 - Gain code maps to powers of two
// RULE12 - Host writes zero to reserved bits
`timescale 1ns/1ps
module adccfg_regs (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter core events
   input wire logic [1:0] chan_result_i,
   input wire logic data_taken_i,
   // Decoded configuration
   output adccfg_pkg::adccfg_cfg_t cfg_o,
   // Conversion ready pin
   output logic conversion_ready_pin_o,
   output logic conversion_ready_pin_oe,
   // Interrupt
   output logic irq_o
);

   // Register storage
   logic [15:0] mode_q, mode_d;
   logic [15:0] clock_q, clock_d;
   logic [15:0] gain_q, gain_d;
   logic [2:0] irq_stat_q, irq_stat_d;
   logic [2:0] irq_mask_q, irq_mask_d;
   logic [31:0] prdata_q, prdata_d;
   // Ready tracking
   logic [1:0] pend_q, pend_d;
   logic avail_q, avail_d;
   adccfg_pkg::adccfg_pin_t st_q, st_d;
   logic [2:0] cnt_q, cnt_d;
   logic pin_o_q, pin_o_d;
   logic pin_oe_q, pin_oe_d;
   // Decoded fields
   logic [1:0] chan_on;
   logic [1:0] ready_source_select;
   logic ready_idle_float;
   logic ready_pulse_format;
   logic fast_ratio_override;
   logic [2:0] oversample_ratio_sel;
   logic [1:0] power_level_sel;
   logic [2:0] chan0_amp_gain;
   logic [2:0] chan1_amp_gain;
   // Bus strobes
   logic wr_en, rd_setup, access, mapped;
   // Ready events
   logic [1:0] arrive;
   logic trig;

   // Field extraction
   assign chan_on = {clock_q[adccfg_pkg::CLK_CH1_BIT],
                     clock_q[adccfg_pkg::CLK_CH0_BIT]}; // RULE4
   assign ready_source_select = mode_q[adccfg_pkg::MODE_SEL_LSB +: 2];
   assign ready_idle_float = mode_q[adccfg_pkg::MODE_FLOAT_BIT];
   assign ready_pulse_format = mode_q[adccfg_pkg::MODE_FMT_BIT];
   assign fast_ratio_override = clock_q[adccfg_pkg::CLK_FAST_BIT];
   assign oversample_ratio_sel = clock_q[adccfg_pkg::CLK_OSR_LSB +: 3];
   assign power_level_sel = clock_q[adccfg_pkg::CLK_PWR_LSB +: 2];
   assign chan0_amp_gain = gain_q[adccfg_pkg::GAIN_CH0_LSB +: 3]; // RULE10
   assign chan1_amp_gain = gain_q[adccfg_pkg::GAIN_CH1_LSB +: 3]; // RULE10

   // Bus decode; zero wait states, so pready is always high
   assign access = psel && penable;
   assign wr_en = access && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped = (paddr == adccfg_pkg::ADDR_MODE) ||
                   (paddr == adccfg_pkg::ADDR_CLOCK) ||
                   (paddr == adccfg_pkg::ADDR_GAIN) ||
                   (paddr == adccfg_pkg::ADDR_IRQ_STAT) ||
                   (paddr == adccfg_pkg::ADDR_IRQ_MASK);
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = prdata_q;

   // Configuration decode for the converter core
   always_comb begin
      cfg_o.chan_on = chan_on; // RULE4
      // Override wins over the ratio field
      if (fast_ratio_override) begin
         cfg_o.osr = adccfg_pkg::OSR_FAST; // RULE5
      end else begin
         case (oversample_ratio_sel) // RULE6
            3'h0: cfg_o.osr = 15'h0080;
            3'h1: cfg_o.osr = 15'h0100;
            3'h2: cfg_o.osr = 15'h0200;
            3'h3: cfg_o.osr = 15'h0400;
            3'h4: cfg_o.osr = 15'h0800;
            3'h5: cfg_o.osr = 15'h1000;
            3'h6: cfg_o.osr = 15'h2000;
            default: cfg_o.osr = 15'h3f80;
         endcase
      end
      // Both upper codes select high resolution
      case (power_level_sel) // RULE7
         2'h0: cfg_o.power = adccfg_pkg::PWR_VLOW;
         2'h1: cfg_o.power = adccfg_pkg::PWR_LOW;
         default: cfg_o.power = adccfg_pkg::PWR_HRES;
      endcase
      // Gains are powers of two of the code
      cfg_o.gain0 = 8'h01 << chan0_amp_gain; // RULE11
      cfg_o.amp_gain_config = 8'h01 << chan1_amp_gain; // RULE11
   end

   // Register file next values
   always_comb begin
      mode_d = mode_q;
      clock_d = clock_q;
      gain_d = gain_q;
      irq_mask_d = irq_mask_q;
      prdata_d = prdata_q;
      if (wr_en) begin
         case (paddr)
            adccfg_pkg::ADDR_MODE: begin
               mode_d = pwdata[15:0];
            end
            adccfg_pkg::ADDR_CLOCK: begin
               // Upper six bits stay zero
               clock_d = pwdata[15:0] & adccfg_pkg::CLOCK_WMASK; // RULE8
            end
            adccfg_pkg::ADDR_GAIN: begin
               // Reserved bits are kept as written
               gain_d = pwdata[15:0]; // RULE10
            end
            adccfg_pkg::ADDR_IRQ_MASK: begin
               irq_mask_d = pwdata[2:0];
            end
            default: begin
               irq_mask_d = irq_mask_q;
            end
         endcase
      end
      // Read data is fetched in the setup cycle so it leaves a flop
      if (rd_setup) begin
         case (paddr)
            adccfg_pkg::ADDR_MODE: prdata_d = {16'h0000, mode_q};
            adccfg_pkg::ADDR_CLOCK: prdata_d = {16'h0000, clock_q}; // RULE8
            adccfg_pkg::ADDR_GAIN: prdata_d = {16'h0000, gain_q}; // RULE9
            adccfg_pkg::ADDR_IRQ_STAT: prdata_d = {29'h0, irq_stat_q};
            adccfg_pkg::ADDR_IRQ_MASK: prdata_d = {29'h0, irq_mask_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Ready source and pin driver next values
   always_comb begin
      arrive = chan_result_i & chan_on; // RULE4
      // A new arrival beats a simultaneous clear
      pend_d = (pend_q & ~{2{data_taken_i}}) | arrive;
      case (ready_source_select) // RULE1
         adccfg_pkg::SEL_LAGGING: avail_d = (chan_on != 2'h0) &&
                                  ((pend_d & chan_on) == chan_on);
         adccfg_pkg::SEL_ANY: avail_d = |(pend_d & chan_on);
         // Leading: first enabled arrival makes data available
         default: avail_d = |(pend_d & chan_on);
      endcase
      // In OR mode every arrival signals, otherwise only the rise of avail
      if (ready_source_select == adccfg_pkg::SEL_ANY) begin
         trig = |arrive; // RULE1
      end else begin
         trig = avail_d && !avail_q; // RULE1
      end
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         adccfg_pkg::PIN_IDLE: begin
            if (trig && ready_pulse_format) begin
               st_d = adccfg_pkg::PIN_PULSE; // RULE3
               cnt_d = adccfg_pkg::PULSE_CYC - 3'h1;
            end else if (trig) begin
               st_d = adccfg_pkg::PIN_HOLD; // RULE3
            end
         end
         adccfg_pkg::PIN_HOLD: begin
            // Held low until the result is taken
            if (!avail_d) begin
               st_d = adccfg_pkg::PIN_IDLE;
            end
         end
         adccfg_pkg::PIN_PULSE: begin
            // A new event restarts the pulse
            if (trig) begin
               cnt_d = adccfg_pkg::PULSE_CYC - 3'h1;
            end else if (cnt_q == 3'h0) begin
               st_d = adccfg_pkg::PIN_IDLE;
            end else begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         default: begin
            st_d = adccfg_pkg::PIN_IDLE;
         end
      endcase
      // Pin levels follow the next state so they leave flops
      if (st_d == adccfg_pkg::PIN_IDLE) begin
         pin_o_d = 1'b1; // RULE2
         pin_oe_d = !ready_idle_float; // RULE2
      end else begin
         pin_o_d = 1'b0; // RULE3
         pin_oe_d = 1'b1;
      end
   end

   // Interrupt status: hardware set wins over a write-one clear
   always_comb begin
      irq_stat_d = irq_stat_q;
      if (wr_en && paddr == adccfg_pkg::ADDR_IRQ_STAT) begin
         irq_stat_d = irq_stat_q & ~pwdata[2:0];
      end
      irq_stat_d[adccfg_pkg::IRQ_READY_BIT] =
         irq_stat_d[adccfg_pkg::IRQ_READY_BIT] | trig;
      irq_stat_d[adccfg_pkg::IRQ_CH0_BIT] =
         irq_stat_d[adccfg_pkg::IRQ_CH0_BIT] | arrive[0];
      irq_stat_d[adccfg_pkg::IRQ_CH1_BIT] =
         irq_stat_d[adccfg_pkg::IRQ_CH1_BIT] | arrive[1];
   end

   assign irq_o = |(irq_stat_q & irq_mask_q);
   assign conversion_ready_pin_o = pin_o_q;
   assign conversion_ready_pin_oe = pin_oe_q;

   // All state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= adccfg_pkg::MODE_RST; // RULE1
         clock_q <= adccfg_pkg::CLOCK_RST; // RULE8
         gain_q <= adccfg_pkg::GAIN_RST; // RULE9
         irq_stat_q <= adccfg_pkg::IRQ_RST;
         irq_mask_q <= adccfg_pkg::IRQ_RST;
         prdata_q <= 32'h0000_0000;
         pend_q <= 2'h0;
         avail_q <= 1'b0;
         st_q <= adccfg_pkg::PIN_IDLE;
         cnt_q <= 3'h0;
         pin_o_q <= 1'b1;
         pin_oe_q <= 1'b1;
      end else begin
         mode_q <= mode_d;
         clock_q <= clock_d;
         gain_q <= gain_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         prdata_q <= prdata_d;
         pend_q <= pend_d;
         avail_q <= avail_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         pin_o_q <= pin_o_d;
         pin_oe_q <= pin_oe_d;
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_fmt_trig;
      trig && ready_pulse_format && st_q == adccfg_pkg::PIN_IDLE;
   endsequence
   sequence s_low_four;
      (pin_oe_q && !pin_o_q) [*4];
   endsequence

   chk_lag_waits: assert property ( // RULE1
      ready_source_select == 2'h0 && chan_on == 2'h3 &&
      pend_q == 2'h1 |-> !avail_q)
      else $error("lagging mode signalled before all channels");
   chk_any_flags: assert property ( // RULE1
      ready_source_select == 2'h1 && |(pend_q & chan_on) |-> avail_q)
      else $error("or mode missed an enabled result");
   chk_idle_level: assert property ( // RULE2
      st_q == adccfg_pkg::PIN_IDLE && !$past(ready_idle_float) &&
      !$past(trig) |-> pin_oe_q && pin_o_q)
      else $error("idle pin not driven high");
   chk_idle_float: assert property ( // RULE2
      st_q == adccfg_pkg::PIN_IDLE && $past(ready_idle_float) |-> !pin_oe_q)
      else $error("idle pin not released");
   chk_hold_low: assert property ( // RULE3
      trig && !ready_pulse_format && st_q == adccfg_pkg::PIN_IDLE |=>
      !pin_o_q && pin_oe_q && st_q == adccfg_pkg::PIN_HOLD)
      else $error("ready not held low");
   chk_pulse_width: assert property ( // RULE3
      s_fmt_trig |=> s_low_four ##1 (pin_o_q || $past(trig, 4) ||
      $past(trig, 3) || $past(trig, 2) || $past(trig)))
      else $error("ready pulse width wrong");
   chk_chan_gate: assert property ( // RULE4
      chan_result_i[0] && !chan_on[0] && !pend_q[0] |=> !pend_q[0])
      else $error("disabled channel result latched");
   chk_fast_ratio: assert property ( // RULE5
      fast_ratio_override |-> cfg_o.osr == 15'h0040)
      else $error("override ratio not 64");
   chk_ratio_map: assert property ( // RULE6
      !fast_ratio_override && oversample_ratio_sel != 3'h7 |->
      cfg_o.osr == (15'h0080 << oversample_ratio_sel))
      else $error("ratio decode wrong");
   chk_power_map: assert property ( // RULE7
      power_level_sel[1] |-> cfg_o.power == adccfg_pkg::PWR_HRES)
      else $error("power decode wrong");
   chk_clock_upper: assert property ( // RULE8
      wr_en && paddr == adccfg_pkg::ADDR_CLOCK |=>
      clock_q[15:10] == 6'h00 && clock_q[9:0] == $past(pwdata[9:0]))
      else $error("clock register write wrong");
   chk_gain_write: assert property ( // RULE10
      wr_en && paddr == adccfg_pkg::ADDR_GAIN |=>
      gain_q == $past(pwdata[15:0]))
      else $error("gain register write lost");
   chk_gain_map: assert property ( // RULE11
      cfg_o.amp_gain_config[gain_q[6:4]] && $onehot(cfg_o.amp_gain_config))
      else $error("gain decode wrong");

endmodule // adccfg_regs

// ===== dv/adccfg_host_model.sv
/*
 * Host controller model facing the conversion-ready pin: resolves the pin
 * wire with a board pull-up and answers each ready indication with a
 * one-cycle data-taken pulse after a set delay.
 * Assumes one pclk domain; outputs change right after rising edges.
 */
`timescale 1ns/1ps
module adccfg_host_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Ready pin as driven by the device
   input wire logic pin_o,
   input wire logic pin_oe,
   // Answer control from the bench
   input wire logic auto_take,
   input wire logic [3:0] take_delay,
   // Host side view
   output logic pin_wire,
   output logic data_taken
);
   logic wire_q; // Wire level one cycle back
   logic [4:0] cnt_q; // Cycles left before the take, zero when idle

   // Pull-up holds the wire high while the device floats the pin
   assign pin_wire = pin_oe ? pin_o : 1'b1;

   // A falling wire starts the delayed read of the result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wire_q <= 1'b1;
         cnt_q <= 5'h00;
         data_taken <= 1'b0;
      end else begin
         wire_q <= pin_wire;
         // Pulse exactly once per indication
         data_taken <= (cnt_q == 5'h01);
         if (auto_take && wire_q && !pin_wire) begin
            cnt_q <= {1'b0, take_delay} + 5'h01;
         end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
         end
      end
   end
endmodule // adccfg_host_model

// ===== dv/adccfg_regs_tb.sv
/*
 * Self-checking bench for the converter configuration registers: APB
 * master tasks, ready pin traffic through the host model, interrupts.
 * Assumes pready may stretch; every wait is bounded.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   total_checks++; \
   if ((got) !== (ex)) begin \
      n_errors++; \
      $display("ERROR %s exp %h got %h", nm, ex, got); \
   end \
end
module adccfg_regs_tb;
   // Bus and pin signals
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] chan_result;
   logic data_taken, pin_o, pin_oe, pin_wire, irq, err, auto_take;
   logic [3:0] take_delay;
   adccfg_pkg::adccfg_cfg_t cfg; // Decoded configuration
   int n_errors, total_checks;

   adccfg_regs i_adccfg_regs (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chan_result_i(chan_result),
      .data_taken_i(data_taken), .cfg_o(cfg),
      .conversion_ready_pin_o(pin_o), .conversion_ready_pin_oe(pin_oe),
      .irq_o(irq));
   adccfg_host_model i_adccfg_host_model (.pclk(pclk), .presetn(presetn),
      .pin_o(pin_o), .pin_oe(pin_oe), .auto_take(auto_take),
      .take_delay(take_delay), .pin_wire(pin_wire),
      .data_taken(data_taken));

   // Free-running 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #(adccfg_pkg::CLK_PERIOD_NS / 2) pclk = ~pclk;
   end

   task automatic report_and_stop();
      if (n_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         n_errors++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] ex,
                        input string nm);
      apb(1'b0, a, 32'h0);
      `CHK(nm, ex, rd)
   endtask

   // One-cycle result strobe, then let the edge's updates land
   task automatic pulse(input logic [1:0] c);
      @(posedge pclk);
      chan_result <= c;
      @(posedge pclk);
      chan_result <= 2'b00;
      #1;
   endtask

   // Bounded wait for the host to take the data and the wire to rise
   task automatic wait_idle();
      int i;
      for (i = 0; i < 40 && pin_wire !== 1'b1; i++) @(posedge pclk);
      #1;
      `CHK("idle wire", 1'b1, pin_wire)
      // A pin that never rises ends the run at once
      if (pin_wire !== 1'b1) report_and_stop();
   endtask

   initial begin
      int c;
      int n;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      chan_result = 2'b00;
      auto_take = 1'b1;
      take_delay = 4'h6;
      n_errors = 0;
      total_checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      // Reset state of pin, decode and registers
      `CHK("pin", 1'b1, pin_o)
      `CHK("pin oe", 1'b1, pin_oe)
      `CHK("chan_on", 2'b11, cfg.chan_on)
      `CHK("osr", 15'd1024, cfg.osr)
      `CHK("power", adccfg_pkg::PWR_HRES, cfg.power)
      `CHK("gains", 16'h0101, {cfg.amp_gain_config, cfg.gain0})
      rdchk(adccfg_pkg::ADDR_MODE, 32'h0510, "mode");
      rdchk(adccfg_pkg::ADDR_CLOCK, 32'h030e, "clock");
      rdchk(adccfg_pkg::ADDR_GAIN, 32'h0, "gain");
      // Top clock bits read zero; reserved gain bits keep ones
      wr(adccfg_pkg::ADDR_CLOCK, 32'hffff_ff3f);
      rdchk(adccfg_pkg::ADDR_CLOCK, 32'h033f, "clock ro");
      wr(adccfg_pkg::ADDR_GAIN, 32'h0000_ffff);
      rdchk(adccfg_pkg::ADDR_GAIN, 32'hffff, "gain rsv");
      // Every ratio and power code, reserved bits written zero
      for (c = 0; c < 8; c++) begin
         wr(adccfg_pkg::ADDR_CLOCK, 32'h0300 | (c << 2) | (c % 4));
         `CHK("osr", (c == 7) ? 15'd16256 : 15'(128 << c), cfg.osr)
         `CHK("power", (c % 4 == 0) ? adccfg_pkg::PWR_VLOW : (c % 4 == 1)
            ? adccfg_pkg::PWR_LOW : adccfg_pkg::PWR_HRES, cfg.power)
      end
      wr(adccfg_pkg::ADDR_CLOCK, 32'h033e);
      `CHK("osr fast", 15'd64, cfg.osr)
      wr(adccfg_pkg::ADDR_CLOCK, 32'h030e);
      // Every gain code on both channels
      for (c = 0; c < 8; c++) begin
         wr(adccfg_pkg::ADDR_GAIN, (c << 4) | (7 - c));
         `CHK("amp_gain_config", 8'(1 << c), cfg.amp_gain_config)
         `CHK("gain0", 8'(1 << (7 - c)), cfg.gain0)
         rdchk(adccfg_pkg::ADDR_GAIN, (c << 4) | (7 - c), "gain");
      end
      // Unmapped place refuses and reads zero
      apb(1'b0, 8'h20, 32'h0);
      `CHK("slverr", 1'b1, err)
      `CHK("unmapped", 32'h0, rd)
      // All source selector codes; lagging waits for both channels
      for (c = 0; c < 4; c++) begin
         wr(adccfg_pkg::ADDR_MODE, 32'h0510 | (c << 2));
         pulse(2'b01);
         `CHK("ready", c == 0, pin_o)
         if (c == 0) begin
            pulse(2'b10);
            `CHK("ready lag", 1'b0, pin_o)
         end
         repeat (3) @(posedge pclk);
         #1;
         `CHK("held low", 1'b0, pin_o)
         wait_idle();
      end
      // Fixed-width low pulse
      wr(adccfg_pkg::ADDR_MODE, 32'h0515);
      pulse(2'b01);
      n = 0;
      for (c = 0; c < 8; c++) begin
         if (pin_o === 1'b0) n++;
         @(posedge pclk);
         #1;
      end
      `CHK("pulse width", 32'(adccfg_pkg::PULSE_CYC), n)
      wait_idle();
      // Floating idle pin, driven low while data waits
      wr(adccfg_pkg::ADDR_MODE, 32'h0516);
      repeat (2) @(posedge pclk);
      #1;
      `CHK("float oe", 1'b0, pin_oe)
      pulse(2'b01);
      `CHK("drive oe", 1'b1, pin_oe)
      `CHK("drive low", 1'b0, pin_o)
      wait_idle();
      `CHK("float again", 1'b0, pin_oe)
      // Disabled channel is ignored
      wr(adccfg_pkg::ADDR_MODE, 32'h0514);
      wr(adccfg_pkg::ADDR_CLOCK, 32'h020e);
      `CHK("chan_on", 2'b10, cfg.chan_on)
      pulse(2'b01);
      `CHK("ch0 off", 1'b1, pin_o)
      pulse(2'b10);
      `CHK("ch1 on", 1'b0, pin_o)
      wait_idle();
      // Sticky status, mask and write-one clear
      wr(adccfg_pkg::ADDR_CLOCK, 32'h030e);
      wr(adccfg_pkg::ADDR_IRQ_STAT, 32'h7);
      rdchk(adccfg_pkg::ADDR_IRQ_STAT, 32'h0, "irq stat");
      pulse(2'b01);
      rdchk(adccfg_pkg::ADDR_IRQ_STAT, 32'h3, "irq stat");
      `CHK("irq masked", 1'b0, irq)
      wr(adccfg_pkg::ADDR_IRQ_MASK, 32'h2);
      `CHK("irq", 1'b1, irq)
      wr(adccfg_pkg::ADDR_IRQ_STAT, 32'h2);
      `CHK("irq clr", 1'b0, irq)
      rdchk(adccfg_pkg::ADDR_IRQ_STAT, 32'h1, "irq left");
      wait_idle();
      report_and_stop();
   end
endmodule // adccfg_regs_tb
